// file: design/cpm_pkg.sv
package cpm_pkg;

  typedef enum logic [1:0] {
    CPM_PRIV_THREAD  = 2'b00,
    CPM_USER_THREAD  = 2'b01,
    CPM_PRIV_HANDLER = 2'b10
  } cpm_state_e;

  localparam int          CPM_CTRL_W      = 2;
  localparam int          CPM_CTRL_LEVEL  = 0;
  localparam int          CPM_CTRL_ALTSTK = 1;
  localparam logic [1:0]  CPM_CTRL_RESET  = 2'h0;
  localparam logic [31:0] CPM_SP_RESET    = 32'h0000_0000;
  localparam int          CPM_NEST_W      = 8;
  localparam logic [7:0]  CPM_NEST_MAX    = 8'hff;
  localparam logic [7:0]  CPM_NEST_ONE    = 8'h01;
  localparam logic [7:0]  CPM_NEST_ZERO   = 8'h00;

  // Opcode patterns for the privileged-only instructions and for the 32-bit encoding prefix.
  localparam logic [15:0] CPM_CPS_MASK    = 16'hffe8;
  localparam logic [15:0] CPM_CPS_MATCH   = 16'hb660;
  localparam logic [15:0] CPM_MSR_MASK    = 16'hffe0;
  localparam logic [15:0] CPM_MSR_MATCH   = 16'hf380;
  localparam logic [15:0] CPM_MRS_MATCH   = 16'hf3ef;
  localparam logic [2:0]  CPM_WIDE_PREFIX = 3'h7;
  localparam logic [1:0]  CPM_WIDE_NOT    = 2'h0;

  // Start of the system space that holds configuration and debug components.
  localparam logic [31:0] CPM_SYS_BASE    = 32'he000_0000;

endpackage

// file: design/cpm_dec_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cpm_dec_if;
  logic [31:0] instr;
  logic        isa_legacy;
  logic [31:0] acc_addr;
  logic        is32;
  logic        is_priv;
  logic        restricted;
  logic        legacy;

  modport decoder (
    input  instr,
    input  isa_legacy,
    input  acc_addr,
    output is32,
    output is_priv,
    output restricted,
    output legacy
  );

  modport core (
    output instr,
    output isa_legacy,
    output acc_addr,
    input  is32,
    input  is_priv,
    input  restricted,
    input  legacy
  );
endinterface
`default_nettype wire

// file: design/cpm_decode.sv
`timescale 1ns/1ps
`default_nettype none
module cpm_decode (
  cpm_dec_if.decoder dec
);
  import cpm_pkg::*;

  logic [15:0] hw0;
  logic [15:0] hw1;

  assign hw0 = dec.instr[15:0];
  assign hw1 = dec.instr[31:16];

  // A first halfword with top bits 111 and a nonzero next pair opens a 32-bit encoding.
  assign dec.is32 = (hw0[15:13] == CPM_WIDE_PREFIX) && (hw0[12:11] != CPM_WIDE_NOT);

  // Legacy full-width code has no decoder here, so it is reported instead of executed.
  assign dec.legacy = dec.isa_legacy;

  always_comb begin
    dec.is_priv = 1'b0;
    if (!dec.is32) begin
      dec.is_priv = ((hw0 & CPM_CPS_MASK) == CPM_CPS_MATCH);
    end else begin
      // System register moves always carry a set top bit in their second halfword.
      dec.is_priv = (((hw0 & CPM_MSR_MASK) == CPM_MSR_MATCH) || (hw0 == CPM_MRS_MATCH)) &&
                    hw1[15];
    end
    dec.is_priv = dec.is_priv && !dec.isa_legacy;
  end

  assign dec.restricted = (dec.acc_addr >= CPM_SYS_BASE);
endmodule // cpm_decode
`default_nettype wire

// file: design/cpm_top.sv
`timescale 1ns/1ps
`default_nettype none
module cpm_top (
  input  wire logic                        i_clock,
  input  wire logic                        i_resetn,
  input  wire logic                        i_exc_entry,
  input  wire logic                        i_exc_return,
  input  wire logic                        i_instr_valid,
  input  wire logic [31:0]                 i_instr,
  input  wire logic                        i_isa_legacy,
  input  wire logic                        i_acc_valid,
  input  wire logic [31:0]                 i_acc_addr,
  input  wire logic                        i_ctrl_wr,
  input  wire logic [cpm_pkg::CPM_CTRL_W-1:0] i_ctrl_wdata,
  input  wire logic                        i_sp_wr,
  input  wire logic [31:0]                 i_sp_wdata,
  input  wire logic                        i_spreg_wr,
  input  wire logic                        i_spreg_sel_psp,
  input  wire logic [31:0]                 i_spreg_wdata,
  output logic [1:0]                       o_state,
  output logic                             o_handler_mode,
  output logic                             o_user_level,
  output logic [cpm_pkg::CPM_CTRL_W-1:0]   o_ctrl,
  output logic                             o_sp_sel_psp,
  output logic [31:0]                      o_active_sp,
  output logic [31:0]                      o_main_stack_pointer,
  output logic [31:0]                      o_process_stack_pointer,
  output logic                             o_instr_is32,
  output logic                             o_fault,
  output logic                             o_undef
);
  import cpm_pkg::*;

  cpm_dec_if dec ();

  cpm_decode u_decode (
    .dec (dec.decoder)
  );

  assign dec.instr      = i_instr;
  assign dec.isa_legacy = i_isa_legacy;
  assign dec.acc_addr   = i_acc_addr;

  // Stack pointers are word aligned, so the two low bits never store.
  function automatic logic [31:0] sp_align(input logic [31:0] value);
    sp_align = {value[31:2], 2'b00};
  endfunction

  cpm_state_e        state;
  cpm_state_e        next_state;
  logic [7:0]        nest;
  logic [7:0]        next_nest;
  logic              ctrl_user;
  logic              next_ctrl_user;
  logic              thread_alt;
  logic              next_thread_alt;
  logic [31:0]       main_stack_pointer;
  logic [31:0]       next_msp;
  logic [31:0]       process_stack_pointer;
  logic [31:0]       next_psp;
  logic              fault;
  logic              next_fault;
  logic              undef;
  logic              next_undef;
  logic              is32;
  logic              next_is32;
  logic              user_now;
  logic              handler_now;
  logic              use_psp;
  logic              offend;

  assign user_now    = (state == CPM_USER_THREAD);
  assign handler_now = (state == CPM_PRIV_HANDLER);
  assign use_psp     = user_now && thread_alt;

  // Only a user-level request can offend; privileged requests always pass.
  assign offend = user_now && ((i_instr_valid && !i_isa_legacy && dec.is_priv) ||
                               (i_acc_valid && dec.restricted) ||
                               i_ctrl_wr || i_spreg_wr);

  always_comb begin
    next_nest       = nest;
    next_ctrl_user  = ctrl_user;
    next_thread_alt = thread_alt;
    next_msp        = main_stack_pointer;
    next_psp        = process_stack_pointer;
    next_fault      = offend;
    next_undef      = i_instr_valid && dec.legacy;
    next_is32       = is32;
    if (i_instr_valid) begin
      next_is32 = dec.is32 && !dec.legacy;
    end
    // Entry wins over a return in the same cycle; the depth saturates, never wraps.
    if (i_exc_entry) begin
      if (nest != CPM_NEST_MAX) begin
        next_nest = nest + CPM_NEST_ONE;
      end
    end else if (i_exc_return && (nest != CPM_NEST_ZERO)) begin
      next_nest = nest - CPM_NEST_ONE;
    end
    if (i_ctrl_wr && !user_now) begin
      next_ctrl_user = i_ctrl_wdata[CPM_CTRL_LEVEL];
      if (!handler_now) begin
        next_thread_alt = i_ctrl_wdata[CPM_CTRL_ALTSTK];
      end
    end
    if (i_sp_wr) begin
      if (use_psp) begin
        next_psp = sp_align(i_sp_wdata);
      end else begin
        next_msp = sp_align(i_sp_wdata);
      end
    end else if (i_spreg_wr && !user_now) begin
      if (i_spreg_sel_psp) begin
        next_psp = sp_align(i_spreg_wdata);
      end else begin
        next_msp = sp_align(i_spreg_wdata);
      end
    end
    if (next_nest != CPM_NEST_ZERO) begin
      next_state = CPM_PRIV_HANDLER;
    end else if (next_ctrl_user) begin
      next_state = CPM_USER_THREAD;
    end else begin
      next_state = CPM_PRIV_THREAD;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state      <= CPM_PRIV_THREAD;
      nest       <= CPM_NEST_ZERO;
      ctrl_user  <= CPM_CTRL_RESET[CPM_CTRL_LEVEL];
      thread_alt <= CPM_CTRL_RESET[CPM_CTRL_ALTSTK];
      main_stack_pointer        <= CPM_SP_RESET;
      process_stack_pointer        <= CPM_SP_RESET;
      fault      <= 1'b0;
      undef      <= 1'b0;
      is32       <= 1'b0;
    end else begin
      state      <= next_state;
      nest       <= next_nest;
      ctrl_user  <= next_ctrl_user;
      thread_alt <= next_thread_alt;
      main_stack_pointer        <= next_msp;
      process_stack_pointer        <= next_psp;
      fault      <= next_fault;
      undef      <= next_undef;
      is32       <= next_is32;
    end
  end

  assign o_state                 = state;
  assign o_handler_mode          = handler_now;
  assign o_user_level            = user_now;
  // The stored alternate-stack choice survives exceptions but reads 0 in handler mode.
  assign o_ctrl                  = {thread_alt && !handler_now, ctrl_user};
  assign o_sp_sel_psp            = use_psp;
  assign o_active_sp             = use_psp ? process_stack_pointer : main_stack_pointer;
  assign o_main_stack_pointer    = main_stack_pointer;
  assign o_process_stack_pointer = process_stack_pointer;
  assign o_instr_is32            = is32;
  assign o_fault                 = fault;
  assign o_undef                 = undef;

  // Handler mode must follow the exception depth, which also rules out a user handler.
  a_no_user_handler: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (o_state != 2'h3) && !(o_handler_mode && o_user_level) &&
    (o_handler_mode == (nest != CPM_NEST_ZERO)))
    else $error("illegal level and mode combination");

  a_user_priv_fault: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (user_now && i_acc_valid && dec.restricted) |=> o_fault)
    else $error("restricted user access did not fault");

  a_user_ctrl_kept: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (user_now && i_ctrl_wr && !i_exc_entry) |=> (o_fault && $stable(o_ctrl)))
    else $error("user write changed mode control");

  a_priv_no_fault: assert property (@(posedge i_clock) disable iff (!i_resetn)
    !user_now |=> !o_fault)
    else $error("privileged request faulted");

  a_entry_handler: assert property (@(posedge i_clock) disable iff (!i_resetn)
    i_exc_entry |=> (o_handler_mode && !o_user_level))
    else $error("exception entry did not reach privileged handler");

  a_last_return_thread: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_exc_return && !i_exc_entry && (nest == CPM_NEST_ONE)) |=> !o_handler_mode)
    else $error("last exception return stayed in handler mode");

  a_sp_bank_apart: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_sp_wr && o_sp_sel_psp) |=> $stable(o_main_stack_pointer))
    else $error("process stack write disturbed main stack pointer");

  a_legacy_undef: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_instr_valid && i_isa_legacy) |=> (o_undef && !o_instr_is32))
    else $error("legacy instruction was decoded");

  a_legacy_no_fault: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_instr_valid && i_isa_legacy && !i_acc_valid && !i_ctrl_wr && !i_spreg_wr) |=> !o_fault)
    else $error("legacy instruction raised an access fault");

  a_ctrl_level_wr: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_ctrl_wr && !user_now) |=> (o_ctrl[0] == $past(i_ctrl_wdata[0])))
    else $error("privileged write of level bit lost");

  a_alt_zero_hdl: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_handler_mode |-> !o_ctrl[1])
    else $error("alternate stack bit set in handler mode");

  a_psp_user_only: assert property (@(posedge i_clock) disable iff (!i_resetn)
    o_sp_sel_psp |-> (!o_handler_mode && o_ctrl[0] && (o_active_sp == process_stack_pointer)))
    else $error("process stack used outside user thread");

  c_user_fault: cover property (@(posedge i_clock) disable iff (!i_resetn) o_user_level ##1 o_fault);
  c_nested_exc: cover property (@(posedge i_clock) disable iff (!i_resetn) nest == 8'h02);
  c_psp_in_use: cover property (@(posedge i_clock) disable iff (!i_resetn) o_sp_sel_psp && i_sp_wr);
  c_legacy_undef: cover property (@(posedge i_clock) disable iff (!i_resetn) o_undef);
  c_back_thread: cover property (@(posedge i_clock) disable iff (!i_resetn) $fell(o_handler_mode));
endmodule // cpm_top
`default_nettype wire

// file: design/cpm_placeholder_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: verif/cpm_tb.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cpm_pkg::*;
  logic        i_clock = 1'b0, i_resetn = 1'b0, i_exc_entry = 1'b0, i_exc_return = 1'b0;
  logic        i_instr_valid = 1'b0, i_isa_legacy = 1'b0, i_acc_valid = 1'b0, i_ctrl_wr = 1'b0;
  logic        i_sp_wr = 1'b0, i_spreg_wr = 1'b0, i_spreg_sel_psp = 1'b0;
  logic [31:0] i_instr = 32'h0000_0000, i_acc_addr = 32'h0000_0000;
  logic [31:0] i_sp_wdata = 32'h0000_0000, i_spreg_wdata = 32'h0000_0000;
  logic [1:0]  i_ctrl_wdata = 2'h0, o_state, o_ctrl;
  logic        o_handler_mode, o_user_level, o_sp_sel_psp, o_instr_is32, o_fault, o_undef;
  logic [31:0] o_active_sp, o_main_stack_pointer, o_process_stack_pointer;
  int          bad_count = 0, check_count = 0, cyc = 0;
  logic [31:0] priv_ops [3] = '{32'h0000_b662, 32'h8800_f380, 32'h8000_f3ef};

  cpm_top u_cpm_top (.i_clock(i_clock), .i_resetn(i_resetn), .i_exc_entry(i_exc_entry),
    .i_exc_return(i_exc_return), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .i_isa_legacy(i_isa_legacy), .i_acc_valid(i_acc_valid), .i_acc_addr(i_acc_addr),
    .i_ctrl_wr(i_ctrl_wr), .i_ctrl_wdata(i_ctrl_wdata), .i_sp_wr(i_sp_wr),
    .i_sp_wdata(i_sp_wdata), .i_spreg_wr(i_spreg_wr), .i_spreg_sel_psp(i_spreg_sel_psp),
    .i_spreg_wdata(i_spreg_wdata), .o_state(o_state), .o_handler_mode(o_handler_mode),
    .o_user_level(o_user_level), .o_ctrl(o_ctrl), .o_sp_sel_psp(o_sp_sel_psp),
    .o_active_sp(o_active_sp), .o_main_stack_pointer(o_main_stack_pointer),
    .o_process_stack_pointer(o_process_stack_pointer), .o_instr_is32(o_instr_is32),
    .o_fault(o_fault), .o_undef(o_undef));

  always #4 i_clock = ~i_clock;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Strobes drop at the taking edge; outputs are read once that edge has settled.
  task go;
    @(posedge i_clock);
    i_exc_entry   <= 1'b0;
    i_exc_return  <= 1'b0;
    i_instr_valid <= 1'b0;
    i_acc_valid   <= 1'b0;
    i_ctrl_wr     <= 1'b0;
    i_sp_wr       <= 1'b0;
    i_spreg_wr    <= 1'b0;
    #1;
  endtask

  task automatic req_instr(input logic [31:0] v, input logic leg);
    @(posedge i_clock);
    i_instr_valid <= 1'b1;
    i_instr       <= v;
    i_isa_legacy  <= leg;
    go();
  endtask

  task automatic req_acc(input logic [31:0] a);
    @(posedge i_clock);
    i_acc_valid <= 1'b1;
    i_acc_addr  <= a;
    go();
  endtask

  task automatic req_ctrl(input logic [1:0] d);
    @(posedge i_clock);
    i_ctrl_wr    <= 1'b1;
    i_ctrl_wdata <= d;
    go();
  endtask

  task automatic req_spreg(input logic sel, input logic [31:0] d);
    @(posedge i_clock);
    i_spreg_wr      <= 1'b1;
    i_spreg_sel_psp <= sel;
    i_spreg_wdata   <= d;
    go();
  endtask

  task automatic req_exc(input logic ent, input logic ret);
    @(posedge i_clock);
    i_exc_entry  <= ent;
    i_exc_return <= ret;
    go();
  endtask

  task t_reset;
    chk("state", o_state, 32'h0);
    chk("ctrl", o_ctrl, 32'h0);
    chk("psp_sel", o_sp_sel_psp, 32'h0);
    chk("msp", o_main_stack_pointer, CPM_SP_RESET);
    chk("psp", o_process_stack_pointer, CPM_SP_RESET);
    chk("fault", o_fault, 32'h0);
  endtask

  // A reset in mid-run must drop the stored alternate-stack bit and both pointers.
  task t_rst_mid;
    @(posedge i_clock);
    i_resetn <= 1'b0;
    @(posedge i_clock);
    i_resetn <= 1'b1;
    #1;
    t_reset();
    req_ctrl(2'h3);
    chk("state_after", o_state, 32'h1);
  endtask

  task t_priv;
    req_spreg(1'b0, 32'h2000_1007);
    chk("msp", o_main_stack_pointer, 32'h2000_1004);
    req_spreg(1'b1, 32'h3000_000b);
    chk("psp", o_process_stack_pointer, 32'h3000_0008);
    chk("msp_kept", o_main_stack_pointer, 32'h2000_1004);
    req_ctrl(2'h2);
    chk("ctrl", o_ctrl, 32'h2);
    chk("active", o_active_sp, 32'h2000_1004);
    req_acc(CPM_SYS_BASE);
    chk("acc_fault", o_fault, 32'h0);
    foreach (priv_ops[i]) begin
      req_instr(priv_ops[i], 1'b0);
      chk("op_fault", o_fault, 32'h0);
    end
  endtask

  task t_user;
    req_ctrl(2'h3);
    chk("state", o_state, 32'h1);
    chk("user", o_user_level, 32'h1);
    chk("active", o_active_sp, 32'h3000_0008);
    @(posedge i_clock);
    i_sp_wr    <= 1'b1;
    i_sp_wdata <= 32'h3000_0100;
    go();
    chk("psp_wr", o_process_stack_pointer, 32'h3000_0100);
    req_acc(32'he000_ed00);
    chk("acc_fault", o_fault, 32'h1);
    go();
    chk("fault_end", o_fault, 32'h0);
    req_acc(32'hdfff_fffc);
    chk("low_acc", o_fault, 32'h0);
    foreach (priv_ops[i]) begin
      req_instr(priv_ops[i], 1'b0);
      chk("op_fault", o_fault, 32'h1);
    end
    req_instr(32'h0000_b662, 1'b1);
    chk("leg_undef", o_undef, 32'h1);
    chk("leg_no_fault", o_fault, 32'h0);
    go();
    chk("undef_end", o_undef, 32'h0);
    req_ctrl(2'h0);
    chk("ctrl_fault", o_fault, 32'h1);
    chk("ctrl_kept", o_ctrl, 32'h3);
    req_spreg(1'b0, 32'h0000_0040);
    chk("spreg_fault", o_fault, 32'h1);
    chk("msp_kept", o_main_stack_pointer, 32'h2000_1004);
  endtask

  task t_exc;
    req_exc(1'b1, 1'b0);
    chk("state", o_state, 32'h2);
    chk("handler", o_handler_mode, 32'h1);
    chk("ctrl", o_ctrl, 32'h1);
    chk("active", o_active_sp, 32'h2000_1004);
    req_ctrl(2'h0);
    chk("h_fault", o_fault, 32'h0);
    req_exc(1'b1, 1'b1);
    req_exc(1'b0, 1'b1);
    chk("nested", o_state, 32'h2);
    req_exc(1'b0, 1'b1);
    chk("thread", o_state, 32'h0);
    chk("ctrl_back", o_ctrl, 32'h2);
    chk("psp_sel", o_sp_sel_psp, 32'h0);
  endtask

  task t_decode;
    req_instr(32'h0000_4600, 1'b0);
    chk("is32", o_instr_is32, 32'h0);
    req_instr(32'hf800_f000, 1'b0);
    chk("is32", o_instr_is32, 32'h1);
    req_instr(32'h0000_e000, 1'b0);
    chk("is32", o_instr_is32, 32'h0);
    req_instr(32'he1a0_0000, 1'b1);
    chk("undef", o_undef, 32'h1);
    chk("no_fault", o_fault, 32'h0);
  endtask

  // A hung bench is cut short well beyond the roughly 60 cycles the run needs.
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      wrap_up();
    end
  end

  initial begin
    repeat (3) @(posedge i_clock);
    i_resetn <= 1'b1;
    #1;
    t_reset();
    t_priv();
    t_user();
    t_exc();
    t_decode();
    t_rst_mid();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
